// ---- link_param_bank.sv ----
/*
 Link parameter register bank of the receiving converter, with decoded
 parameter outputs for the deframer. Assumes the controller issues one
 strobe at a time and waits for ack. Also holds the helper that turns
 minus-one fields into registered counts.
*/
// Summary of operation
// RQ1 - Lane-count bit 7 enables descrambling
// RQ2 - Lane-count low five bits: lanes minus one
// RQ3 - Octets register is octets minus one
// RQ4 - Multiframe low bits: frames minus one
// RQ5 - Converter register: converters minus one
// RQ6 - Host writes zero control bits
// RQ7 - Host sets resolution field to fifteen
// RQ8 - Subclass register top bits select subclass
// RQ9 - Host sets sample bits field fifteen
// RQ10 - Host writes version field one
// RQ11 - Version low bits: samples minus one
// RQ12 - Density bit 7 is high-density flag
// RQ13 - Host writes zero control words
// RQ14 - Deskew mask bit n deskews lane
// RQ15 - Direct octets register is plain count
// RQ16 - Lane enable bit n enables lane
// RQ17 - Host programs one consistent mode first
`timescale 1ns/1ps
`default_nettype none
`include "link_param_defines.svh"
module link_param_bank
   import link_param_pkg::*;
(
   input wire logic clk_sys,                          // System clock
   input wire logic nrst,                             // Sync reset, low
   link_param_if.bank bus,                            // Register port
   output logic descramble_en,                        // Descrambler on
   output logic [5:0] lanes,                          // Lanes per link
   output logic [8:0] octets,                         // Octets per frame
   output logic [5:0] frames,                         // Frames/multiframe
   output logic [8:0] converters,                     // Converters
   output logic [2:0] subclass,                       // Link subclass
   output logic [5:0] samples,                        // Samples/conv/frame
   output logic high_density,                         // Samples span lanes
   output logic [7:0] deskew_lanes,                   // Lanes to deskew
   output logic [7:0] octets_direct,                  // Octet count as is
   output logic [7:0] lane_enables                    // Enabled lanes
);
   typedef struct packed {
      byte_t [`LP_NUM_REGS-1:0] regs;
      byte_t rdata;
      logic ack;
   } bank_s;

   bank_s state_reg, state_next;
   logic [3:0] idx;
   logic hit;

   // Offset decode to storage index
   always_comb begin
      hit = 1'b1;
      idx = 4'h0;
      unique case (bus.addr)
         `LP_OFF_LANES: idx = 4'h0;
         `LP_OFF_OCTETS_M1: idx = 4'h1;
         `LP_OFF_FRAMES: idx = 4'h2;
         `LP_OFF_CONVERTERS: idx = 4'h3;
         `LP_OFF_RESOLUTION: idx = 4'h4;
         `LP_OFF_SUBCLASS: idx = 4'h5;
         `LP_OFF_VERSION: idx = 4'h6;
         `LP_OFF_DENSITY: idx = 4'h7;
         `LP_OFF_DESKEW: idx = 4'h8;
         `LP_OFF_OCTETS_DIRECT: idx = 4'h9;
         `LP_OFF_LANE_EN: idx = 4'hA;
         default: hit = 1'b0;
      endcase
   end

   // Write stores, read returns; unmapped reads give zero, writes drop
   always_comb begin
      state_next = state_reg;
      state_next.ack = bus.req;
      if (bus.req) begin
         if (bus.wr && hit) begin
            state_next.regs[idx] = bus.wdata;
         end
         state_next.rdata = hit ? state_reg.regs[idx] : 8'h00;
         if (bus.wr) begin
            state_next.rdata = 8'h00;
         end
      end
   end

   // One edge moves the whole bank state; reset clears every register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.rdata = state_reg.rdata;
   assign bus.ack = state_reg.ack;

   // Scrambling is one flag; the deframer takes it as a level
   assign descramble_en = state_reg.regs[0][`LP_SCRAMBLE_BIT]; // RQ1

   // Lanes per link from its minus-one field
   count_from_field #(
      .IN_W(5),
      .OUT_W(6)
   ) u_lanes ( // RQ2
      .clk_sys(clk_sys),                              // System clock
      .nrst(nrst),                                    // Sync reset, low
      .field(state_reg.regs[0][4:0]),                 // Lanes minus one
      .count(lanes)                                   // Lanes per link
   );

   // Octets per frame; the full byte is used, so the count needs 9 bits
   count_from_field #(
      .IN_W(8),
      .OUT_W(9)
   ) u_octets ( // RQ3
      .clk_sys(clk_sys),                              // System clock
      .nrst(nrst),                                    // Sync reset, low
      .field(state_reg.regs[1]),                      // Octets minus one
      .count(octets)                                  // Octets per frame
   );

   // Frames per multiframe; the top three bits of the byte are ignored
   count_from_field #(
      .IN_W(5),
      .OUT_W(6)
   ) u_frames ( // RQ4
      .clk_sys(clk_sys),                              // System clock
      .nrst(nrst),                                    // Sync reset, low
      .field(state_reg.regs[2][4:0]),                 // Frames minus one
      .count(frames)                                  // Frames/multiframe
   );

   // Converters per link, again a full byte
   count_from_field #(
      .IN_W(8),
      .OUT_W(9)
   ) u_converters ( // RQ5
      .clk_sys(clk_sys),                              // System clock
      .nrst(nrst),                                    // Sync reset, low
      .field(state_reg.regs[3]),                      // Converters less one
      .count(converters)                              // Converters
   );

   // Subclass codes above one pass through; the deframer must refuse them
   assign subclass = state_reg.regs[5][7:5]; // RQ8

   // Samples per converter per frame from the version register low bits
   count_from_field #(
      .IN_W(5),
      .OUT_W(6)
   ) u_samples ( // RQ11
      .clk_sys(clk_sys),                              // System clock
      .nrst(nrst),                                    // Sync reset, low
      .field(state_reg.regs[6][4:0]),                 // Samples minus one
      .count(samples)                                 // Samples/conv/frame
   );

   // High-density flag: samples may be split across lanes
   assign high_density = state_reg.regs[7][`LP_DENSITY_BIT]; // RQ12

   // Lane masks and the direct octet count go out as stored; nothing
   // checks them against the lane count, which is the host's duty
   assign deskew_lanes = state_reg.regs[8]; // RQ14
   assign octets_direct = state_reg.regs[9]; // RQ15
   assign lane_enables = state_reg.regs[10]; // RQ16
endmodule : link_param_bank

// Turns a stored minus-one field into the count that it stands for; the
// count is registered, so it trails a register write by one cycle
module count_from_field
   import link_param_pkg::*;
#(
   parameter int IN_W = 5,                            // Field width
   parameter int OUT_W = 6                            // Count width
) (
   input wire logic clk_sys,                          // System clock
   input wire logic nrst,                             // Sync reset, low
   input wire logic [IN_W-1:0] field,                 // Minus-one value
   output logic [OUT_W-1:0] count                     // Decoded count
);
   typedef struct packed {
      logic [OUT_W-1:0] count;
   } count_s;

   count_s state_reg, state_next;

   // Widened first, so the top field code gives a count and not zero
   always_comb begin
      state_next.count = OUT_W'(field) + OUT_W'(1);
   end

   // Reset shows the count of an all-zero field, as the bank clears to zero
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg.count <= OUT_W'(`LP_COUNT_RESET);
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.count;
endmodule : count_from_field
`default_nettype wire

// ---- link_param_ctl.sv ----
/*
 Host-side controller: software reaches it over Avalon-MM and it runs
 single register accesses into the bank. Assumes the bank acks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "link_param_defines.svh"
module link_param_ctl
   import link_param_pkg::*;
(
   input wire logic clk_sys,                          // System clock
   input wire logic nrst,                             // Sync reset, low
   input wire logic [3:0] avs_address,                // Byte address
   input wire logic avs_read,                         // Read request
   input wire logic avs_write,                        // Write request
   input wire logic [31:0] avs_writedata,             // Write data
   output logic [31:0] avs_readdata,                  // Read data
   output logic avs_waitrequest,                      // Stall
   link_param_if.ctl bus                              // Bank port
);
   typedef struct packed {
      ctl_state_e st;
      logic wr;
      logic [11:0] addr;
      byte_t wdata;
      byte_t rdata;
      logic [31:0] rd_out;
      logic rd_ok;
   } ctl_s;

   ctl_s state_reg, state_next;

   // CTRL write bit1 starts write, bit0 alone starts read; other CTRL bits are ignored
   always_comb begin
      state_next = state_reg;
      state_next.rd_ok = 1'b0;
      unique case (state_reg.st)
         ST_IDLE: begin
            if (avs_write && avs_address == `CTL_OFF_ADDR) begin
               state_next.addr = avs_writedata[11:0];
            end
            if (avs_write && avs_address == `CTL_OFF_WDATA) begin
               // RQ6 RQ7 RQ9 RQ10 RQ13 RQ17 are software's duty here
               state_next.wdata = avs_writedata[7:0];
            end
            if (avs_write && avs_address == `CTL_OFF_CTRL &&
                avs_writedata[1:0] != 2'b00) begin
               state_next.wr = avs_writedata[1];
               state_next.st = ST_ISSUE;
            end
         end
         ST_ISSUE: state_next.st = ST_WAIT;
         // Code 3 is never entered; fall back to idle if it shows up
         default: state_next.st = ST_IDLE;
         ST_WAIT: begin
            if (bus.ack) begin
               if (!state_reg.wr) begin
                  state_next.rdata = bus.rdata;
               end
               state_next.st = ST_IDLE;
            end
         end
      endcase
      if (avs_read) begin
         // Pulse, so a read that follows at once still waits for fresh data
         state_next.rd_ok = !state_reg.rd_ok;
         unique case (avs_address)
            `CTL_OFF_ADDR: state_next.rd_out = {20'h00000, state_reg.addr};
            `CTL_OFF_WDATA: state_next.rd_out = {24'h000000, state_reg.wdata};
            `CTL_OFF_STATUS: state_next.rd_out =
               {23'h000000, state_reg.st != ST_IDLE, state_reg.rdata};
            default: state_next.rd_out = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Reads take one wait cycle; writes accepted at once
   assign avs_waitrequest = avs_read && !state_reg.rd_ok;
   assign avs_readdata = state_reg.rd_out;
   assign bus.req = state_reg.st == ST_ISSUE;
   assign bus.wr = state_reg.wr;
   assign bus.addr = state_reg.addr;
   assign bus.wdata = state_reg.wdata;
endmodule : link_param_ctl
`default_nettype wire

// ---- link_param_defines.svh ----
/*
 Register offsets, field positions and mode values of the link parameter
 bank. Assumes inclusion by bare name from design files.
*/
`ifndef LINK_PARAM_DEFINES_SVH
`define LINK_PARAM_DEFINES_SVH

`define LP_ADDR_W 12
`define LP_OFF_LANES 12'h453
`define LP_OFF_OCTETS_M1 12'h454
`define LP_OFF_FRAMES 12'h455
`define LP_OFF_CONVERTERS 12'h456
`define LP_OFF_RESOLUTION 12'h457
`define LP_OFF_SUBCLASS 12'h458
`define LP_OFF_VERSION 12'h459
`define LP_OFF_DENSITY 12'h45A
`define LP_OFF_DESKEW 12'h46C
`define LP_OFF_OCTETS_DIRECT 12'h476
`define LP_OFF_LANE_EN 12'h47D
`define LP_SCRAMBLE_BIT 7
`define LP_DENSITY_BIT 7
`define LP_RESET_VALUE 8'h00
`define LP_COUNT_RESET 9'h001
`define LP_RESOLUTION_16 8'h0F
`define LP_SUBCLASS_BITS_16 5'h0F
`define LP_VERSION_B 3'h1
`define LP_NUM_REGS 11
// Controller register map on the Avalon side (byte addresses)
`define CTL_OFF_CTRL 4'h0
`define CTL_OFF_ADDR 4'h4
`define CTL_OFF_WDATA 4'h8
`define CTL_OFF_STATUS 4'hC

`endif

// ---- link_param_if.sv ----
/*
 Register port joining the configuration controller and the bank.
 Assumes one clock shared by both ends; a one-cycle strobe per access.
*/
`timescale 1ns/1ps
`default_nettype none
interface link_param_if (
   input wire logic clk_sys                           // System clock
);
   logic req;                                         // Access strobe
   logic wr;                                          // 1 write, 0 read
   logic [11:0] addr;                                 // Register offset
   logic [7:0] wdata;                                 // Write data
   logic [7:0] rdata;                                 // Read data
   logic ack;                                         // Access done pulse
   modport bank (input req, wr, addr, wdata, output rdata, ack);
   modport ctl (output req, wr, addr, wdata, input rdata, ack);
endinterface : link_param_if
`default_nettype wire

// ---- link_param_pkg.sv ----
/*
 Types shared by both ends of the link parameter bank.
 Assumes link_param_defines.svh sits in the same folder.
*/
package link_param_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} ctl_state_e;
   typedef logic [7:0] byte_t;
endpackage : link_param_pkg

// ---- link_param_sva.sv ----
/*
 Checker for the register port between controller and bank.
 Assumes the testbench instantiates it beside the interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "link_param_defines.svh"
module link_param_sva (
   input wire logic clk_sys, // Clock
   input wire logic nrst, // Reset, low
   input wire logic req, // Strobe
   input wire logic wr, // Direction
   input wire logic [11:0] addr, // Offset
   input wire logic [7:0] wdata, // Write data
   input wire logic [7:0] rdata, // Read data
   input wire logic ack // Done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [7:0] mirror [256];
   logic [7:0] exp_reg;
   logic mapped;
   // Decoded offsets; the low byte alone tells them apart
   assign mapped = addr inside {`LP_OFF_LANES, `LP_OFF_OCTETS_M1,
      `LP_OFF_FRAMES, `LP_OFF_CONVERTERS, `LP_OFF_RESOLUTION,
      `LP_OFF_SUBCLASS, `LP_OFF_VERSION, `LP_OFF_DENSITY, `LP_OFF_DESKEW,
      `LP_OFF_OCTETS_DIRECT, `LP_OFF_LANE_EN};
   // Shadow of the bank, so a read can be judged without the body
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         for (int i = 0; i < 256; i++) mirror[i] <= 8'h00;
      end else if (req && wr && mapped) begin
         mirror[addr[7:0]] <= wdata;
      end
   end
   // Answer due for the access in flight
   always_ff @(posedge clk_sys) begin
      if (req) begin
         exp_reg <= (!wr && mapped) ? mirror[addr[7:0]] : 8'h00;
      end
   end
   sequence s_answer;
      ##1 ack ##1 !ack;
   endsequence
   a_ack_follows: assert property (req |-> s_answer)
      else $error("ack not one cycle after strobe");
   a_ack_cause: assert property (ack |-> $past(req))
      else $error("ack without strobe");
   a_req_single: assert property (req |=> !req)
      else $error("strobe longer than one cycle");
   a_write_zero: assert property (req && wr |=> rdata == 8'h00)
      else $error("write strobe returned data");
   a_unmapped_zero: assert property (req && !wr && !mapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_read_mirror: assert property (ack |-> rdata == exp_reg)
      else $error("read data differs from written value");
   a_rdata_holds: assert property (!ack |-> $stable(rdata))
      else $error("read data moved between accesses");
   a_no_early_ack: assert property (!req |=> !ack)
      else $error("ack without preceding strobe");
endmodule : link_param_sva
`default_nettype wire

// ---- tb.sv ----
/*
 Bench: loads three link modes over Avalon-MM and checks the decode.
 Assumes design files and checker are compiled ahead of it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "link_param_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
   n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb import link_param_pkg::*;;
   logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic descramble_en, high_density;
   logic [5:0] lanes, frames, samples;
   logic [8:0] octets, converters;
   logic [2:0] subclass;
   logic [7:0] deskew_lanes, octets_direct, lane_enables;
   int n_errors = 0;
   int checks = 0;
   byte_t q;
   logic [11:0] offs [11] = '{`LP_OFF_LANES, `LP_OFF_OCTETS_M1,
      `LP_OFF_FRAMES, `LP_OFF_CONVERTERS, `LP_OFF_RESOLUTION,
      `LP_OFF_SUBCLASS, `LP_OFF_VERSION, `LP_OFF_DENSITY, `LP_OFF_DESKEW,
      `LP_OFF_OCTETS_DIRECT, `LP_OFF_LANE_EN};
   // Four lanes high density, two samples, one lane four octets
   byte_t md [3][11] = '{'{8'h83, 8'h00, 8'h1F, 8'h01, 8'h0F, 8'h2F,
      8'h20, 8'h80, 8'h0F, 8'h01, 8'h0F}, '{8'h03, 8'h01, 8'h0F, 8'h01,
      8'h0F, 8'h0F, 8'h21, 8'h00, 8'h0F, 8'h02, 8'h0F}, '{8'h80, 8'h03,
      8'h0F, 8'h01, 8'h0F, 8'h0F, 8'h20, 8'h00, 8'h01, 8'h04, 8'h01}};
   // Lanes, octets, frames, converters, subclass and samples per mode
   logic [8:0] dec [3][6] = '{'{9'h004, 9'h001, 9'h020, 9'h002, 9'h001,
      9'h001}, '{9'h004, 9'h002, 9'h010, 9'h002, 9'h000, 9'h002},
      '{9'h001, 9'h004, 9'h010, 9'h002, 9'h000, 9'h001}};
   link_param_if bus (.clk_sys(clk_sys));
   link_param_ctl u_link_param_ctl (.clk_sys, .nrst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .bus(bus));
   link_param_bank u_link_param_bank (.clk_sys, .nrst, .bus(bus),
      .descramble_en, .lanes, .octets, .frames, .converters, .subclass,
      .samples, .high_density, .deskew_lanes, .octets_direct, .lane_enables);
   link_param_sva u_link_param_sva (.clk_sys, .nrst, .req(bus.req),
      .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
      .ack(bus.ack));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // One Avalon cycle, held until waitrequest is seen low
   task automatic av(input logic [3:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      int i;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i >= 50) begin
         n_errors++;
         report_and_stop();
      end
      @(posedge clk_sys);
   endtask : av
   // Bank access through the controller, polling busy to the end
   task automatic rg(input logic [11:0] a, input logic w, input byte_t d,
      output byte_t v);
      logic [31:0] r;
      int i;
      av(`CTL_OFF_ADDR, 1'b1, {20'h00000, a}, r);
      if (w) av(`CTL_OFF_WDATA, 1'b1, {24'h000000, d}, r);
      av(`CTL_OFF_CTRL, 1'b1, w ? 32'h2 : 32'h1, r);
      i = 0;
      do begin
         av(`CTL_OFF_STATUS, 1'b0, 32'h0, r);
         i++;
      end while (r[8] !== 1'b0 && i < 20);
      if (r[8] !== 1'b0) begin
         n_errors++;
         report_and_stop();
      end
      v = r[7:0];
   endtask : rg
   initial begin
      nrst = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      `CHK("lanes", 6'h01, lanes)
      rg(12'h460, 1'b1, 8'hA5, q);
      rg(12'h460, 1'b0, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      $display("test unmapped done");
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 11; k++) begin
            rg(offs[k], 1'b1, md[m][k], q);
         end
         for (int k = 0; k < 11; k++) begin
            rg(offs[k], 1'b0, 8'h00, q);
            `CHK("readback", md[m][k], q)
         end
         `CHK("descramble", md[m][0][7], descramble_en)
         `CHK("lanes", dec[m][0], lanes)
         `CHK("octets", dec[m][1], octets)
         `CHK("frames", dec[m][2], frames)
         `CHK("convs", dec[m][3], converters)
         `CHK("subclass", dec[m][4], subclass)
         `CHK("samples", dec[m][5], samples)
         `CHK("density", md[m][7][7], high_density)
         `CHK("deskew", md[m][8], deskew_lanes)
         `CHK("direct", md[m][9], octets_direct)
         `CHK("enables", md[m][10], lane_enables)
         $display("test mode %0d done", m);
      end
      // Reset in mid-run must clear the bank again
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      `CHK("lanes rst", 6'h01, lanes)
      `CHK("enables rst", `LP_RESET_VALUE, lane_enables)
      rg(`LP_OFF_DESKEW, 1'b0, 8'h00, q);
      `CHK("deskew rst", `LP_RESET_VALUE, q)
      $display("test reset done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
